// file: src/cip_pkg.sv
package cip_pkg;

    // register indexes; byte address is four times the index
    localparam logic [7:0] CIP_IDX_CTRL = 8'h00;
    localparam logic [7:0] CIP_IDX_STATUS = 8'h01;
    localparam logic [7:0] CIP_IDX_PRI = 8'h02;
    localparam logic [7:0] CIP_IDX_L1VEC = 8'h03;
    localparam int CIP_ADDR_W = 8;

    // interrupt_control fields
    localparam int CIP_VECTOR_LOCATION_SELECT_BIT = 6;
    localparam int CIP_CVT_BIT = 5;
    localparam int CIP_RR_BIT = 0;
    // executing_level_flags fields
    localparam int CIP_NONMASKABLE_EXECUTING_FLAG_BIT = 7;
    localparam int CIP_L1EX_BIT = 1;
    localparam int CIP_L0EX_BIT = 0;

    localparam logic [7:0] CIP_CTRL_RST = 8'h00;
    localparam logic [7:0] CIP_STATUS_RST = 8'h00;
    localparam logic [7:0] CIP_PRI_RST = 8'h00;
    localparam logic [7:0] CIP_L1VEC_RST = 8'h00;
    localparam logic [7:0] CIP_L1_OFF = 8'h00;

    // compact table slots
    localparam logic [7:0] CIP_CVT_NMI = 8'h01;
    localparam logic [7:0] CIP_CVT_L1 = 8'h02;
    localparam logic [7:0] CIP_CVT_L0 = 8'h03;

    typedef enum logic [1:0] {
        CIP_LVL_NONE = 2'b00,
        CIP_LVL_NORMAL = 2'b01,
        CIP_LVL_HIGH = 2'b11,
        CIP_LVL_NMI = 2'b10
    } cip_level_type;

    // request offered to the cpu core
    typedef struct packed {
        logic valid;
        cip_level_type level;
        logic [7:0] vector;
        logic [7:0] slot;
    } cip_grant_type;

endpackage : cip_pkg

// file: src/cip_regs.sv
// Added by the designer: the APB slave port.
module cip_regs
    import cip_pkg::*;
#(
    parameter int NVEC = 32,
    parameter logic [7:0] NMI_VECTOR = 8'h01
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [CIP_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic unlock_window_i,
    input wire logic nmi_req_i,
    input wire logic [NVEC-1:0] irq_lines_i,
    input wire logic ack_i,
    input wire logic return_from_handler_i,
    output cip_grant_type grant_o,
    output logic vector_location_select_o,
    output logic compact_table_enable_o
);

    // the vector fields are 8 bits wide, so more than 256 lines cannot be named
    if (NVEC < 4 || NVEC > 256) begin : g_bad_nvec
        $error("NVEC must lie between 4 and 256");
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic vector_location_select_r;
    logic cvt_r;
    logic rr_r;
    logic nmi_ex_r;
    logic l1_ex_r;
    logic l0_ex_r;
    logic [7:0] pri_r;
    logic [7:0] l1vec_r;
    logic [31:0] prdata_r;
    cip_grant_type grant_r;
    cip_grant_type grant_nxt;

    logic [7:0] reg_idx;
    logic mapped;
    logic wr_en;

    assign reg_idx = {2'b00, paddr_i[CIP_ADDR_W-1:2]};
    assign mapped = (paddr_i[1:0] == 2'b00) && (reg_idx <= CIP_IDX_L1VEC);
    assign wr_en = psel_i && penable_i && pwrite_i && mapped && pstrb_i[0];

    // zero wait states: read data is caught in the setup cycle
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_r;

    function automatic logic [7:0] read_mux(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            CIP_IDX_CTRL: begin
                v[CIP_VECTOR_LOCATION_SELECT_BIT] = vector_location_select_r;
                v[CIP_CVT_BIT] = cvt_r;
                v[CIP_RR_BIT] = rr_r;
            end
            CIP_IDX_STATUS: begin
                v[CIP_NONMASKABLE_EXECUTING_FLAG_BIT] = nmi_ex_r;
                v[CIP_L1EX_BIT] = l1_ex_r;
                v[CIP_L0EX_BIT] = l0_ex_r;
            end
            CIP_IDX_PRI: v = pri_r;
            CIP_IDX_L1VEC: v = l1vec_r;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_r <= {24'h00_0000, read_mux(reg_idx)};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            vector_location_select_r <= CIP_CTRL_RST[CIP_VECTOR_LOCATION_SELECT_BIT];
            cvt_r <= CIP_CTRL_RST[CIP_CVT_BIT];
            rr_r <= CIP_CTRL_RST[CIP_RR_BIT];
        end else if (wr_en && reg_idx == CIP_IDX_CTRL) begin
            rr_r <= pwdata_i[CIP_RR_BIT];
            if (unlock_window_i) begin
                vector_location_select_r <= pwdata_i[CIP_VECTOR_LOCATION_SELECT_BIT];
                cvt_r <= pwdata_i[CIP_CVT_BIT];
            end
        end
    end

    assign vector_location_select_o = vector_location_select_r;
    assign compact_table_enable_o = cvt_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            l1vec_r <= CIP_L1VEC_RST;
        end else if (wr_en && reg_idx == CIP_IDX_L1VEC) begin
            l1vec_r <= pwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration

    logic ack_l0;
    assign ack_l0 = ack_i && grant_r.valid && grant_r.level == CIP_LVL_NORMAL;

    // software write wins over the hardware update in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pri_r <= CIP_PRI_RST;
        end else if (wr_en && reg_idx == CIP_IDX_PRI) begin
            pri_r <= pwdata_i[7:0];
        end else if (rr_r && ack_l0) begin
            pri_r <= grant_r.vector;
        end
    end

    // first request after vector last, wrapping; {found, vector}
    function automatic logic [8:0] pick(input logic [NVEC-1:0] m, input logic [7:0] last);
        logic [8:0] res;
        int k;
        res = 9'h000;
        for (int i = 0; i < NVEC; i++) begin
            k = (int'(last) + 1 + i) % NVEC;
            if (m[k] && !res[8]) begin
                res = {1'b1, 8'(k)};
            end
        end
        return res;
    endfunction : pick

    logic l1_on;
    logic l1_req;
    logic [NVEC-1:0] l0_mask;
    logic [8:0] l0_pick;

    assign l1_on = (l1vec_r != CIP_L1_OFF) && (int'(l1vec_r) < NVEC);
    assign l1_req = l1_on && irq_lines_i[l1vec_r[$clog2(NVEC)-1:0]];

    always_comb begin
        l0_mask = irq_lines_i;
        if (l1_on) begin
            l0_mask[l1vec_r[$clog2(NVEC)-1:0]] = 1'b0;
        end
    end

    assign l0_pick = pick(l0_mask, pri_r);

    // the offer for the level just granted drops once its flag is set
    always_comb begin
        grant_nxt = '0;
        if (nmi_req_i && !nmi_ex_r) begin
            grant_nxt.valid = 1'b1;
            grant_nxt.level = CIP_LVL_NMI;
            grant_nxt.vector = NMI_VECTOR;
            grant_nxt.slot = cvt_r ? CIP_CVT_NMI : NMI_VECTOR;
        end else if (l1_req && !nmi_ex_r && !l1_ex_r) begin
            grant_nxt.valid = 1'b1;
            grant_nxt.level = CIP_LVL_HIGH;
            grant_nxt.vector = l1vec_r;
            grant_nxt.slot = cvt_r ? CIP_CVT_L1 : l1vec_r;
        end else if (l0_pick[8] && !nmi_ex_r && !l1_ex_r && !l0_ex_r) begin
            grant_nxt.valid = 1'b1;
            grant_nxt.level = CIP_LVL_NORMAL;
            grant_nxt.vector = l0_pick[7:0];
            grant_nxt.slot = cvt_r ? CIP_CVT_L0 : l0_pick[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || ack_i) begin
            grant_r <= '0;
        end else begin
            grant_r <= grant_nxt;
        end
    end

    assign grant_o = grant_r;

    ////////////////////////////////////////////////////////////////////////
    // executing flags

    logic ack_nmi;
    logic ack_l1;
    assign ack_nmi = ack_i && grant_r.valid && grant_r.level == CIP_LVL_NMI;
    assign ack_l1 = ack_i && grant_r.valid && grant_r.level == CIP_LVL_HIGH;

    // a return ends the innermost handler only; a set wins over a clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nmi_ex_r <= CIP_STATUS_RST[CIP_NONMASKABLE_EXECUTING_FLAG_BIT];
        end else if (ack_nmi) begin
            nmi_ex_r <= 1'b1;
        end else if (return_from_handler_i) begin
            nmi_ex_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            l1_ex_r <= CIP_STATUS_RST[CIP_L1EX_BIT];
        end else if (ack_l1) begin
            l1_ex_r <= 1'b1;
        end else if (return_from_handler_i && !nmi_ex_r) begin
            l1_ex_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            l0_ex_r <= CIP_STATUS_RST[CIP_L0EX_BIT];
        end else if (ack_l0) begin
            l0_ex_r <= 1'b1;
        end else if (return_from_handler_i && !nmi_ex_r && !l1_ex_r) begin
            l0_ex_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic ctrl_wr;
    logic pri_wr;
    assign ctrl_wr = wr_en && reg_idx == CIP_IDX_CTRL;
    assign pri_wr = wr_en && reg_idx == CIP_IDX_PRI;

    AST_PROTECTED: assert property (@(posedge clk_i) disable iff (reset_i)
        ctrl_wr && !unlock_window_i |=> vector_location_select_r == $past(vector_location_select_r) && cvt_r == $past(cvt_r))
        else $error("protected bit changed without unlock");

    AST_RR_FREE: assert property (@(posedge clk_i) disable iff (reset_i)
        ctrl_wr |=> rr_r == $past(pwdata_i[CIP_RR_BIT]))
        else $error("round robin bit not written");

    AST_RR_UPDATE: assert property (@(posedge clk_i) disable iff (reset_i)
        rr_r && ack_l0 && !pri_wr |=> pri_r == $past(grant_r.vector))
        else $error("priority not updated on ack");

    AST_FIXED_PRI: assert property (@(posedge clk_i) disable iff (reset_i)
        !rr_r && !pri_wr |=> $stable(pri_r))
        else $error("priority changed in fixed mode");

    AST_NMI_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
        ack_nmi |=> nmi_ex_r ##1 (nmi_ex_r || $past(return_from_handler_i)))
        else $error("nmi flag wrong");

    AST_L1_KEEP: assert property (@(posedge clk_i) disable iff (reset_i)
        l1_ex_r && nmi_ex_r && !ack_l1 |=> l1_ex_r)
        else $error("high flag lost under nmi");

    AST_L0_KEEP: assert property (@(posedge clk_i) disable iff (reset_i)
        l0_ex_r && (nmi_ex_r || l1_ex_r) |=> l0_ex_r)
        else $error("normal flag lost under pre-emption");

    AST_CVT_SLOT: assert property (@(posedge clk_i) disable iff (reset_i)
        grant_r.valid && cvt_r && $stable(cvt_r) && grant_r.level == CIP_LVL_NORMAL
        |-> grant_r.slot == CIP_CVT_L0)
        else $error("compact slot wrong");

    AST_L1_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
        l1vec_r == CIP_L1_OFF && !ack_i |=> !(grant_r.valid && grant_r.level == CIP_LVL_HIGH))
        else $error("high level active while disabled");

    AST_PREEMPT: assert property (@(posedge clk_i) disable iff (reset_i)
        l1_req && l0_ex_r && !l1_ex_r && !nmi_ex_r && !nmi_req_i && !ack_i
        |=> grant_r.valid && grant_r.level == CIP_LVL_HIGH)
        else $error("high level did not pre-empt");

    AST_RESET_PRI: assert property (@(posedge clk_i)
        $fell(reset_i) |-> pri_r == CIP_PRI_RST)
        else $error("priority not reset");

endmodule : cip_regs

// file: sim/cip_cpu_model.sv
module cip_cpu_model
    import cip_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire cip_grant_type grant_i,
    input wire logic ack_en_i,
    input wire logic slow_i,
    input wire logic ret_req_i,
    output logic ack_o,
    output logic ret_o,
    output cip_grant_type taken_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic seen_r;

    // slow mode lets a grant stand a cycle before it is taken
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            seen_r <= 1'b0;
            ack_o <= 1'b0;
            taken_o <= '0;
        end else begin
            seen_r <= grant_i.valid;
            ack_o <= grant_i.valid && ack_en_i && !ack_o && (seen_r || !slow_i);
            if (ack_o) begin
                taken_o <= grant_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        ret_o <= !reset_i && ret_req_i && !ret_o;
    end
endmodule : cip_cpu_model

// file: sim/cpu_interrupt_priority_regs_test.sv
module cpu_interrupt_priority_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import cip_pkg::*;

    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, unl = 1'b0, nmi = 1'b0;
    logic ack_en = 1'b0, slow = 1'b0, ret_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, irq = 32'h0, prdata;
    logic pready, pslverr, ack, ret, vls, cte;
    cip_grant_type grant, taken;
    int miscompares = 0, cmp_count = 0, cyc = 0;

    always #20 clk_i = ~clk_i;

    cip_regs #(.NVEC(32), .NMI_VECTOR(8'h01)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .unlock_window_i(unl), .nmi_req_i(nmi), .irq_lines_i(irq), .ack_i(ack),
        .return_from_handler_i(ret), .grant_o(grant), .vector_location_select_o(vls),
        .compact_table_enable_o(cte));

    cip_cpu_model u_cpu (.clk_i(clk_i), .reset_i(reset_i), .grant_i(grant), .ack_en_i(ack_en),
        .slow_i(slow), .ret_req_i(ret_req), .ack_o(ack), .ret_o(ret), .taken_o(taken));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; idx is the register index, byte address is four times it
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic u, output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= {24'h0, d};
        unl <= u;
        @(posedge clk_i);
        pen <= 1'b1;
        // no local limit: a stuck slave is caught by the bench timeout
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        unl <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic u);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, u, r, e);
    endtask : wr

    task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, 1'b0, r, e);
        chk(what, {24'h0, exp}, r);
    endtask : rchk

    // raise requests, let the cpu model take one grant, then drop the lines
    task automatic serve(input logic [31:0] lines, input logic n, input cip_level_type lv,
                         input logic [7:0] vec, input logic [7:0] slot);
        irq <= lines;
        nmi <= n;
        ack_en <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        ack_en <= 1'b0;
        irq <= 32'h0;
        nmi <= 1'b0;
        @(posedge clk_i);
        chk("grant", {13'h0, 1'b1, lv, vec, slot}, {13'h0, taken});
    endtask : serve

    task automatic leave();
        ret_req <= 1'b1;
        @(posedge clk_i);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : leave

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rchk("ctrl", CIP_IDX_CTRL, 8'h00);
        rchk("pri", CIP_IDX_PRI, 8'h00);
        rchk("l1vec", CIP_IDX_L1VEC, 8'h00);
        chk("vls rst", 32'h0, {31'h0, vls});
        chk("cte rst", 32'h0, {31'h0, cte});
        wr(CIP_IDX_STATUS, 8'hff, 1'b1);
        rchk("status", CIP_IDX_STATUS, 8'h00);
        apb(1'b0, 8'h04, 8'h00, 1'b0, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
    endtask : t_reset

    task automatic t_ctrl();
        wr(CIP_IDX_CTRL, 8'hff, 1'b0);
        rchk("ctrl plain", CIP_IDX_CTRL, 8'h01);
        wr(CIP_IDX_CTRL, 8'hff, 1'b1);
        rchk("ctrl unlocked", CIP_IDX_CTRL, 8'h61);
        chk("vls", 32'h1, {31'h0, vls});
        chk("cte", 32'h1, {31'h0, cte});
        wr(CIP_IDX_CTRL, 8'h00, 1'b1);
        chk("vls off", 32'h0, {31'h0, vls});
    endtask : t_ctrl

    task automatic t_fixed();
        serve(32'h88, 1'b0, CIP_LVL_NORMAL, 8'h03, 8'h03);
        leave();
        rchk("pri fixed", CIP_IDX_PRI, 8'h00);
        wr(CIP_IDX_PRI, 8'h03, 1'b0);
        serve(32'h88, 1'b0, CIP_LVL_NORMAL, 8'h07, 8'h07);
        leave();
        wr(CIP_IDX_PRI, 8'h07, 1'b0);
        serve(32'h48, 1'b0, CIP_LVL_NORMAL, 8'h03, 8'h03);
        leave();
        wr(CIP_IDX_PRI, 8'h00, 1'b0);
    endtask : t_fixed

    task automatic t_rr();
        slow <= 1'b1;
        wr(CIP_IDX_CTRL, 8'h01, 1'b0);
        serve(32'h24, 1'b0, CIP_LVL_NORMAL, 8'h02, 8'h02);
        rchk("pri rr", CIP_IDX_PRI, 8'h02);
        leave();
        serve(32'h24, 1'b0, CIP_LVL_NORMAL, 8'h05, 8'h05);
        leave();
        rchk("pri rr2", CIP_IDX_PRI, 8'h05);
        wr(CIP_IDX_CTRL, 8'h00, 1'b0);
        wr(CIP_IDX_PRI, 8'h00, 1'b0);
        slow <= 1'b0;
    endtask : t_rr

    task automatic t_levels();
        wr(CIP_IDX_L1VEC, 8'h09, 1'b0);
        serve(32'h10, 1'b0, CIP_LVL_NORMAL, 8'h04, 8'h04);
        serve(32'h200, 1'b0, CIP_LVL_HIGH, 8'h09, 8'h09);
        rchk("status high", CIP_IDX_STATUS, 8'h03);
        serve(32'h0, 1'b1, CIP_LVL_NMI, 8'h01, 8'h01);
        rchk("status nmi", CIP_IDX_STATUS, 8'h83);
        leave();
        rchk("status back", CIP_IDX_STATUS, 8'h03);
        leave();
        rchk("status resume", CIP_IDX_STATUS, 8'h01);
        leave();
        rchk("status idle", CIP_IDX_STATUS, 8'h00);
        wr(CIP_IDX_L1VEC, 8'h00, 1'b0);
        serve(32'h200, 1'b0, CIP_LVL_NORMAL, 8'h09, 8'h09);
        leave();
    endtask : t_levels

    task automatic t_cvt();
        wr(CIP_IDX_CTRL, 8'h20, 1'b1);
        wr(CIP_IDX_L1VEC, 8'h09, 1'b0);
        serve(32'h0, 1'b1, CIP_LVL_NMI, 8'h01, CIP_CVT_NMI);
        leave();
        serve(32'h200, 1'b0, CIP_LVL_HIGH, 8'h09, CIP_CVT_L1);
        leave();
        serve(32'h10, 1'b0, CIP_LVL_NORMAL, 8'h04, CIP_CVT_L0);
        leave();
    endtask : t_cvt

    ////////////////////////////////////////////////////////////////////////////////
    // whole run is a few hundred cycles; ceiling leaves ample margin
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_ctrl();
        t_fixed();
        t_rr();
        t_levels();
        t_cvt();
        final_report();
    end
endmodule : cpu_interrupt_priority_regs_test
